// ===== hdl/low_power_mode_control_defs.vh
// constants for the low-power mode controller: register map, field positions, warm-up counts
// assumes an AHB-Lite slave decoding 32-bit aligned words
//
// Overview of operation
// - writing halt bit enters idle
// - halt write completes, then fetch frozen
// - idle keeps peripheral clocks running
// - enabled interrupt during idle ends idle
// - hardware clears halt bit on idle exit
// - return resumes after idle-entering instruction
// - any reset ends idle
// - stop gates every on-chip clock; code gates core, peripheral and crystal only, not clk or ringOscEn
// - deep halt write enters stop immediately
// - six enabled external interrupts wake stop
// - reset pin always leaves stop
// - supply trip resets in stop when enabled
// - flash warm-up of 65536 cycles after stop
// - crystal warm-up added without ring oscillator; code counts it from stop exit alongside the flash warm-up
// - ring select runs ring, flag shows source
// - oscillator-fail ignores stop-stopped oscillator
`ifndef LOW_POWER_MODE_CONTROL_DEFS_VH
`define LOW_POWER_MODE_CONTROL_DEFS_VH
`define ADDR_POWER_CONTROL 8'h00
`define ADDR_EXT_IRQ_FLAGS 8'h04
`define ADDR_STATUS 8'h08
`define BIT_CPU_HALT 0
`define BIT_DEEP_HALT 1
`define BIT_BANDGAP_EN 2
`define BIT_RING_SEL 1
`define BIT_RING_ACTIVE 3
`define FLASH_WARM_CYCLES 65536
`define XTAL_WARM_CYCLES 65536
`define WARM_CNT_W 17
`endif

// ===== hdl/lpm_sync.v
// three-stage synchroniser for an asynchronous level; output changes when stages two and three agree
// assumes the input comes from a pin outside the clk domain
`timescale 1ns/1ps
module lpm_sync
(
	input wire clk,
	input wire sys_rst,
	input wire din,
	output reg dout
);
reg s1;
reg s2;
reg s3;
always @(posedge clk)
begin
	if (sys_rst)
	begin
		s1 <= 1'b0;
		s2 <= 1'b0;
		s3 <= 1'b0;
		dout <= 1'b0;
	end
	else
	begin
		s1 <= din;
		s2 <= s1;
		s3 <= s2;
		if (s2 == s3)
			dout <= s3;
	end
end
endmodule // lpm_sync

// ===== hdl/lpm_warm_counter.v
// down counter used for flash and crystal warm-up delays
// assumes load comes from the controller in the clk domain
`timescale 1ns/1ps
`include "low_power_mode_control_defs.vh"
module lpm_warm_counter
(
	input wire clk,
	input wire sys_rst,
	input wire load,
	input wire [`WARM_CNT_W-1:0] loadValue,
	output wire done
);
reg [`WARM_CNT_W-1:0] count;
always @(posedge clk)
begin
	if (sys_rst)
		count <= {`WARM_CNT_W{1'b0}};
	else if (load)
		count <= loadValue;
	else if (count != {`WARM_CNT_W{1'b0}})
		count <= count - {{(`WARM_CNT_W-1){1'b0}}, 1'b1};
end
assign done = (count == {`WARM_CNT_W{1'b0}}) & ~load;
endmodule // lpm_warm_counter

// ===== hdl/low_power_mode_control.v
// idle/stop low-power controller with AHB-Lite register access and clock-gating outputs
// assumes cpu signals its fetch point and interrupt return; pins are asynchronous
//
// Added by the designer: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`include "low_power_mode_control_defs.vh"
module low_power_mode_control
#(
	parameter [`WARM_CNT_W-1:0] FLASH_WARM = `FLASH_WARM_CYCLES,
	parameter [`WARM_CNT_W-1:0] XTAL_WARM = `XTAL_WARM_CYCLES
)
(
	input wire clk,
	input wire sys_rst,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	input wire [5:0] extIrqPin,
	input wire irqPending,
	input wire resetPin,
	input wire supplyBelowTrip,
	input wire oscFailRaw,
	input wire cpuReset,
	output wire cpuHold,
	output wire periphClkEn,
	output wire coreClkEn,
	output wire xtalEn,
	output wire ringOscEn,
	output reg bandgapReset,
	output wire oscFailReset,
	output wire idleWake
);
localparam ST_RUN = 5'b00001;
localparam ST_IDLE = 5'b00010;
localparam ST_STOP = 5'b00100;
localparam ST_FLASH = 5'b01000;
localparam ST_XTAL = 5'b10000;
reg [4:0] state;
reg [4:0] next_state;
reg cpuHaltRequest;
reg deepHaltRequest;
reg bandgapStopResetEnable;
reg ringOscSelect;
reg ringOscActiveFlag;
reg [5:0] extIrqEnable;
reg addrPhase;
reg addrWrite;
reg [7:0] addrOffset;
wire [5:0] extIrqSync;
wire resetPinSync;
wire supplySync;
wire oscFailSync;
wire flashDone;
wire xtalDone;
wire wakeStop;
wire anyReset;
wire regWrite;
reg flashLoad;
reg xtalLoad;
genvar gi;
generate
	for (gi = 0; gi < 6; gi = gi + 1)
	begin : g_irq
		lpm_sync u_sync
		(
			.clk(clk),
			.sys_rst(sys_rst),
			.din(extIrqPin[gi]),
			.dout(extIrqSync[gi])
		);
	end
endgenerate
lpm_sync u_rst_sync
(
	.clk(clk),
	.sys_rst(sys_rst),
	.din(resetPin),
	.dout(resetPinSync)
);
lpm_sync u_sup_sync
(
	.clk(clk),
	.sys_rst(sys_rst),
	.din(supplyBelowTrip),
	.dout(supplySync)
);
lpm_sync u_osc_sync
(
	.clk(clk),
	.sys_rst(sys_rst),
	.din(oscFailRaw),
	.dout(oscFailSync)
);
lpm_warm_counter u_flash
(
	.clk(clk),
	.sys_rst(sys_rst),
	.load(flashLoad),
	.loadValue(FLASH_WARM),
	.done(flashDone)
);
lpm_warm_counter u_xtal
(
	.clk(clk),
	.sys_rst(sys_rst),
	.load(xtalLoad),
	.loadValue(XTAL_WARM),
	.done(xtalDone)
);
// the controller itself keeps running on clk in stop; only gated outputs stop
assign anyReset = resetPinSync | cpuReset;
assign wakeStop = |(extIrqSync & extIrqEnable);
assign hreadyout = 1'b1;
assign hresp = 1'b0;
assign regWrite = addrPhase & addrWrite;
// the write instruction completes before hold rises, so the next fetch is the one frozen
assign cpuHold = (state != ST_RUN) | (ringOscActiveFlag & 1'b0);
// a ring flag left over from the last exit must not reopen peripheral clocks in a new stop
assign periphClkEn = (state == ST_RUN) | (state == ST_IDLE) | (ringOscActiveFlag & (state != ST_STOP))
	| (state == ST_FLASH);
assign coreClkEn = (state == ST_RUN) | (state == ST_FLASH) | (state == ST_XTAL);
assign xtalEn = (state != ST_STOP);
assign ringOscEn = ringOscActiveFlag;
assign oscFailReset = oscFailSync & (state != ST_STOP) & (state != ST_XTAL);
assign idleWake = (state == ST_IDLE) & irqPending;
always @*
begin
	next_state = state;
	flashLoad = 1'b0;
	xtalLoad = 1'b0;
	case (state)
		ST_RUN:
		begin
			if (regWrite && addrOffset == `ADDR_POWER_CONTROL && hwdata[`BIT_DEEP_HALT])
				next_state = ST_STOP;
			else if (regWrite && addrOffset == `ADDR_POWER_CONTROL && hwdata[`BIT_CPU_HALT])
				next_state = ST_IDLE;
		end
		ST_IDLE:
		begin
			if (irqPending)
				next_state = ST_RUN;
		end
		ST_STOP:
		begin
			if (wakeStop || (bandgapStopResetEnable && supplySync))
			begin
				next_state = ST_FLASH;
				flashLoad = 1'b1;
				xtalLoad = 1'b1;
			end
		end
		ST_FLASH:
		begin
			if (flashDone)
				next_state = (ringOscSelect || xtalDone) ? ST_RUN : ST_XTAL;
		end
		ST_XTAL:
		begin
			if (xtalDone)
				next_state = ST_RUN;
		end
		default:
			next_state = ST_RUN;
	endcase
	// a reset out of stop still needs the full warm-up, so the counters start here too
	if (anyReset && state == ST_STOP)
	begin
		flashLoad = 1'b1;
		xtalLoad = 1'b1;
	end
end
always @(posedge clk)
begin
	if (sys_rst)
	begin
		state <= ST_RUN;
		cpuHaltRequest <= 1'b0;
		deepHaltRequest <= 1'b0;
		bandgapStopResetEnable <= 1'b0;
		ringOscSelect <= 1'b0;
		ringOscActiveFlag <= 1'b0;
		extIrqEnable <= 6'h00;
		addrPhase <= 1'b0;
		addrWrite <= 1'b0;
		addrOffset <= 8'h00;
		bandgapReset <= 1'b0;
	end
	else
	begin
		addrPhase <= hsel & hready & htrans[1];
		addrWrite <= hwrite;
		addrOffset <= haddr[7:0];
		bandgapReset <= (state == ST_STOP) & bandgapStopResetEnable & supplySync;
		if (anyReset)
		begin
			state <= (state == ST_STOP || state == ST_FLASH) ? ST_FLASH : ST_RUN;
			cpuHaltRequest <= 1'b0;
			deepHaltRequest <= 1'b0;
			ringOscActiveFlag <= 1'b0;
		end
		else
		begin
			state <= next_state;
			if (state == ST_STOP && next_state == ST_FLASH)
				ringOscActiveFlag <= ringOscSelect;
			else if (ringOscActiveFlag && xtalDone && state == ST_RUN)
				ringOscActiveFlag <= 1'b0;
			if (regWrite && addrOffset == `ADDR_POWER_CONTROL)
			begin
				cpuHaltRequest <= hwdata[`BIT_CPU_HALT] & ~hwdata[`BIT_DEEP_HALT];
				deepHaltRequest <= hwdata[`BIT_DEEP_HALT];
				bandgapStopResetEnable <= hwdata[`BIT_BANDGAP_EN];
			end
			else
			begin
				if (state == ST_IDLE && next_state != ST_IDLE)
					cpuHaltRequest <= 1'b0;
				if (state == ST_STOP && next_state != ST_STOP)
					deepHaltRequest <= 1'b0;
			end
			if (regWrite && addrOffset == `ADDR_EXT_IRQ_FLAGS)
			begin
				ringOscSelect <= hwdata[`BIT_RING_SEL];
				extIrqEnable <= hwdata[13:8];
			end
		end
	end
end
always @(posedge clk)
begin
	if (sys_rst)
		hrdata <= 32'h00000000;
	else if (hsel && hready && htrans[1] && !hwrite)
	begin
		case (haddr[7:0])
			`ADDR_POWER_CONTROL: hrdata <= {29'h0, bandgapStopResetEnable, deepHaltRequest, cpuHaltRequest};
			`ADDR_EXT_IRQ_FLAGS: hrdata <= {18'h0, extIrqEnable, 4'h0, ringOscActiveFlag, 1'b0, ringOscSelect, 1'b0};
			`ADDR_STATUS: hrdata <= {27'h0, state};
			default: hrdata <= 32'h00000000;
		endcase
	end
end
endmodule // low_power_mode_control

// ===== tb/low_power_mode_control_sva.sv
// assertions on the low-power controller ports
// assumes hsel high and hready fed from hreadyout
`timescale 1ns/1ps
module low_power_mode_control_sva
#(
	parameter int FLASH_WARM = 20
)
(
	input wire clk,
	input wire sys_rst,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [31:0] hwdata,
	input wire hreadyout,
	input wire hresp,
	input wire cpuHold,
	input wire periphClkEn,
	input wire coreClkEn,
	input wire xtalEn,
	input wire bandgapReset,
	input wire oscFailReset,
	input wire idleWake
);
	reg wrPc, prevX, warm;
	reg [16:0] warmCnt;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// warm marks a stop exit still held, so its length can be bounded
	always @(posedge clk)
	begin
		prevX <= xtalEn;
		wrPc <= !sys_rst && htrans[1] && hwrite && haddr[7:0] == 8'h00;
		warmCnt <= (!prevX && xtalEn) ? 17'h1 : warmCnt + 17'h1;
		if (sys_rst || !cpuHold)
			warm <= 1'h0;
		else if (!prevX && xtalEn)
			warm <= 1'h1;
	end
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus not okay");
	a_halt_idle: assert property (wrPc && hwdata[1:0] == 2'h1 |=> cpuHold && periphClkEn && xtalEn)
		else $error("no idle");
	a_stop_entry: assert property (wrPc && hwdata[1] |=> !coreClkEn && !periphClkEn && !xtalEn)
		else $error("no stop");
	a_stop_clocks: assert property (!xtalEn |-> !coreClkEn && !periphClkEn)
		else $error("clock in stop");
	a_idle_wake: assert property (idleWake && !wrPc |=> !cpuHold)
		else $error("idle kept");
	a_gap_stop: assert property ($rose(bandgapReset) |-> !$past(xtalEn))
		else $error("trip outside stop");
	a_flash_hold: assert property (warm && !cpuHold |-> warmCnt >= FLASH_WARM - 1 && warmCnt <= FLASH_WARM + 3)
		else $error("warm-up length");
	a_osc_quiet: assert property (!xtalEn |-> !oscFailReset)
		else $error("osc fail in stop");
	cover property (idleWake);
	cover property (warm && !cpuHold);
	cover property ($rose(bandgapReset));
endmodule // low_power_mode_control_sva
bind low_power_mode_control low_power_mode_control_sva #(.FLASH_WARM(FLASH_WARM)) chk (.clk, .sys_rst, .haddr,
	.htrans, .hwrite, .hwdata, .hreadyout, .hresp, .cpuHold, .periphClkEn, .coreClkEn, .xtalEn, .bandgapReset,
	.oscFailReset, .idleWake);

// ===== tb/low_power_mode_control_tb.sv
// bench for the low-power controller
// assumes a zero-wait bus slave and short warm-up counts
`timescale 1ns/1ps
module low_power_mode_control_tb;
	localparam logic [16:0] WARM = 17'h14;
	logic clk = 1'h0, sys_rst = 1'h1, hwrite = 1'h0, irqPending = 1'h0, resetPin = 1'h0, cpuReset = 1'h0;
	logic supplyBelowTrip = 1'h0, oscFailRaw = 1'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [5:0] extIrqPin = 6'h00;
	wire hreadyout, cpuHold, periphClkEn, coreClkEn, xtalEn, bandgapReset, oscFailReset;
	wire [31:0] hrdata;
	int checks = 0, miscompares = 0, ticks = 0;
	low_power_mode_control #(.FLASH_WARM(WARM), .XTAL_WARM(WARM)) dut (.clk, .sys_rst, .hsel(1'h1), .haddr,
		.htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp(), .hrdata, .extIrqPin,
		.irqPending, .resetPin, .supplyBelowTrip, .oscFailRaw, .cpuReset, .cpuHold, .periphClkEn, .coreClkEn,
		.xtalEn, .ringOscEn(), .bandgapReset, .oscFailReset, .idleWake());
	initial forever #20 clk = ~clk;
	task automatic test_done;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		ticks <= ticks + 1;
		if (ticks == 20000)
		begin
			miscompares++;
			test_done();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// the address phase is held until hready, then data until hready again
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [31:0] e);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'h1);
		if (!w)
			chk(hrdata, e);
	endtask
	task automatic waitRun(output int n);
		n = 0;
		while (cpuHold !== 1'h0 && n < 200)
		begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic testRegs;
		bus(8'h08, 1'h0, 32'h0, 32'h1);
		bus(8'h0c, 1'h1, 32'hff, 32'h0);
		bus(8'h0c, 1'h0, 32'h0, 32'h0);
	endtask
	task automatic testIdle;
		bus(8'h00, 1'h1, 32'h1, 32'h0);
		tick(1);
		chk({cpuHold, periphClkEn, xtalEn}, 3'h7);
		irqPending <= 1'h1;
		tick(3);
		irqPending <= 1'h0;
		chk(cpuHold, 1'h0);
		bus(8'h00, 1'h0, 32'h0, 32'h0);
		bus(8'h00, 1'h1, 32'h1, 32'h0);
		cpuReset <= 1'h1;
		tick(1);
		cpuReset <= 1'h0;
		tick(2);
		bus(8'h08, 1'h0, 32'h0, 32'h1);
	endtask
	task automatic testStop;
		int n;
		for (int i = 0; i < 6; i++)
		begin
			bus(8'h04, 1'h1, (32'h100 << i) | (i > 2 ? 32'h2 : 32'h0), 32'h0);
			bus(8'h00, 1'h1, 32'h2, 32'h0);
			tick(1);
			chk({coreClkEn, periphClkEn, xtalEn}, 3'h0);
			extIrqPin <= 6'h3f ^ (6'h01 << i);
			tick(8);
			bus(8'h08, 1'h0, 32'h0, 32'h4);
			extIrqPin <= 6'h3f;
			waitRun(n);
			extIrqPin <= 6'h00;
			chk(n > WARM && n < 60, 1'h1);
			bus(8'h00, 1'h0, 32'h0, 32'h0);
		end
	endtask
	task automatic testGap;
		int n;
		bus(8'h04, 1'h1, 32'h0, 32'h0);
		bus(8'h00, 1'h1, 32'h2, 32'h0);
		supplyBelowTrip <= 1'h1;
		tick(8);
		chk({bandgapReset, xtalEn}, 2'h0);
		supplyBelowTrip <= 1'h0;
		bus(8'h00, 1'h1, 32'h6, 32'h0);
		supplyBelowTrip <= 1'h1;
		waitRun(n);
		supplyBelowTrip <= 1'h0;
		chk(n < 60, 1'h1);
	endtask
	task automatic testPin;
		int n;
		bus(8'h00, 1'h1, 32'h2, 32'h0);
		oscFailRaw <= 1'h1;
		tick(6);
		chk({oscFailReset, xtalEn}, 2'h0);
		resetPin <= 1'h1;
		tick(8);
		chk(xtalEn, 1'h1);
		resetPin <= 1'h0;
		oscFailRaw <= 1'h0;
		waitRun(n);
		bus(8'h08, 1'h0, 32'h0, 32'h1);
	endtask
	initial
	begin
		tick(8);
		sys_rst <= 1'h0;
		tick(1);
		testRegs();
		testIdle();
		testStop();
		testGap();
		testPin();
		test_done();
	end
endmodule // low_power_mode_control_tb
